// ==== core/ebrw_cfg.svh ====
// timing and field layout constants of the external bus wait control
`ifndef EBRW_CFG_SVH
`define EBRW_CFG_SVH
`define EBRW_CLK_PERIOD_NS 50
`define EBRW_PHASE_UNIT_NS 50
`define EBRW_PHASE_UNIT_CYC ((`EBRW_PHASE_UNIT_NS + `EBRW_CLK_PERIOD_NS - 1) / `EBRW_CLK_PERIOD_NS)
`define EBRW_TIM_W 13
`define EBRW_AB_LSB 0
`define EBRW_AB_W 3
`define EBRW_C_LSB 3
`define EBRW_C_W 2
`define EBRW_D_LSB 5
`define EBRW_D_W 1
`define EBRW_E_LSB 6
`define EBRW_E_W 5
`define EBRW_F_LSB 11
`define EBRW_F_W 2
`define EBRW_CNT_W 6
`define EBRW_ADDR_RST 24'h000000
`define EBRW_DATA_RST 16'h0000
`endif

// ==== core/ebrw_ctrl.sv ====
// external bus cycle engine with wait handshake control
`timescale 1ns/10ps
`include "ebrw_cfg.svh"
module ebrw_ctrl #(
   parameter int NUM_SEL = 4,
   parameter int SEL_W = 2
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_cfg_mux_mode,
   input wire logic i_cfg_ready_enable,
   input wire logic i_cfg_ready_async,
   input wire logic i_cfg_ready_active_high,
   input wire logic [NUM_SEL*`EBRW_TIM_W-1:0] i_per_select_timing_config,
   input wire logic i_req_valid,
   output logic o_req_ready,
   input wire logic i_req_write,
   input wire logic [SEL_W-1:0] i_req_sel,
   input wire logic [23:0] i_req_addr,
   input wire logic [15:0] i_req_wdata,
   input wire logic i_req_high_byte,
   output logic o_rsp_valid,
   output logic [15:0] o_rsp_rdata,
   input wire logic i_ready,
   output logic o_bus_reference_clock_out,
   output logic o_cs_n,
   output logic o_ale,
   output logic o_rd_n,
   output logic o_wr_n,
   output logic o_high_byte_enable_n,
   output logic [23:0] o_demuxed_address_lines,
   input wire logic [15:0] i_muxed_addr_data_lines,
   output logic [15:0] o_muxed_addr_data_lines,
   output logic o_muxed_addr_data_lines_oe_n,
   input wire logic [15:0] i_demuxed_data_lines,
   output logic [15:0] o_demuxed_data_lines,
   output logic o_demuxed_data_lines_oe_n
);
   typedef logic [`EBRW_TIM_W-1:0] ebrw_tim_type;
   typedef logic [`EBRW_CNT_W-1:0] ebrw_cnt_type;

   function automatic ebrw_cnt_type phase_len(input ebrw_pkg::ebrw_state_type s,
                                              input ebrw_tim_type t);
      ebrw_cnt_type n;
      n = '0;
      case (s)
         ebrw_pkg::ST_AB:
         begin
            n = ebrw_cnt_type'(t[`EBRW_AB_LSB +: `EBRW_AB_W]);
            if (n == '0)
               n = ebrw_cnt_type'(1);
         end
         ebrw_pkg::ST_C: n = ebrw_cnt_type'(t[`EBRW_C_LSB +: `EBRW_C_W]);
         ebrw_pkg::ST_D: n = ebrw_cnt_type'(t[`EBRW_D_LSB +: `EBRW_D_W]);
         ebrw_pkg::ST_E: n = ebrw_cnt_type'(t[`EBRW_E_LSB +: `EBRW_E_W]) + ebrw_cnt_type'(1);
         ebrw_pkg::ST_F: n = ebrw_cnt_type'(t[`EBRW_F_LSB +: `EBRW_F_W]);
         default: n = '0;
      endcase
      return ebrw_cnt_type'(n * ebrw_cnt_type'(`EBRW_PHASE_UNIT_CYC));
   endfunction

   // zero-length phases are skipped entirely
   function automatic ebrw_pkg::ebrw_state_type next_phase(input ebrw_pkg::ebrw_state_type cur,
                                                           input ebrw_tim_type t);
      ebrw_pkg::ebrw_state_type s;
      logic done;
      s = cur;
      done = 1'b0;
      for (int k = 0; k < 5; k++)
      begin
         if (!done)
         begin
            case (s)
               ebrw_pkg::ST_IDLE: s = ebrw_pkg::ST_AB;
               ebrw_pkg::ST_AB: s = ebrw_pkg::ST_C;
               ebrw_pkg::ST_C: s = ebrw_pkg::ST_D;
               ebrw_pkg::ST_D: s = ebrw_pkg::ST_E;
               ebrw_pkg::ST_E: s = ebrw_pkg::ST_F;
               default: s = ebrw_pkg::ST_IDLE;
            endcase
            if (s == ebrw_pkg::ST_IDLE || phase_len(s, t) != '0)
               done = 1'b1;
         end
      end
      return s;
   endfunction

   ebrw_pkg::ebrw_state_type state_reg, state_next;
   ebrw_cnt_type cnt_reg, cnt_next;
   ebrw_tim_type tim_reg, tim_next;
   logic wr_reg, wr_next, hb_reg, hb_next;
   logic [23:0] addr_reg, addr_next;
   logic [15:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
   logic rsp_reg, rsp_next, cs_n_reg, cs_n_next, ale_reg, ale_next;
   logic rd_n_reg, rd_n_next, wr_n_reg, wr_n_next, hbe_n_reg, hbe_n_next;
   logic [15:0] mux_out_reg, mux_out_next;
   logic mux_oe_n_reg, mux_oe_n_next, dmx_oe_n_reg, dmx_oe_n_next;
   logic ready_s1_reg, ready_s2_reg;
   logic ready_level, ready_act, accept, sample_pt;

   // the reference clock is the system clock forwarded to the pad
   assign o_bus_reference_clock_out = i_clk;
   // sync mode reads the pin itself for the shortest cycle; async pays two stages
   assign ready_level = i_cfg_ready_async ? ready_s2_reg : i_ready;
   assign ready_act = (ready_level == i_cfg_ready_active_high);
   assign accept = i_req_valid && (state_reg == ebrw_pkg::ST_IDLE);
   assign sample_pt = (state_reg == ebrw_pkg::ST_E) && (cnt_reg == '0);
   assign o_req_ready = (state_reg == ebrw_pkg::ST_IDLE);

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         ready_s1_reg <= 1'b0;
         ready_s2_reg <= 1'b0;
      end
      else
      begin
         ready_s1_reg <= i_ready;
         ready_s2_reg <= ready_s1_reg;
      end
   end

   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      tim_next = tim_reg;
      wr_next = wr_reg;
      hb_next = hb_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      if (accept)
      begin
         tim_next = i_per_select_timing_config[i_req_sel*`EBRW_TIM_W +: `EBRW_TIM_W];
         wr_next = i_req_write;
         hb_next = i_req_high_byte;
         addr_next = i_req_addr;
         wdata_next = i_req_wdata;
         state_next = ebrw_pkg::ST_AB;
         cnt_next = phase_len(ebrw_pkg::ST_AB, tim_next) - ebrw_cnt_type'(1);
      end
      else if (state_reg != ebrw_pkg::ST_IDLE)
      begin
         if (cnt_reg != '0)
            cnt_next = cnt_reg - ebrw_cnt_type'(1);
         else if (state_reg == ebrw_pkg::ST_E && i_cfg_ready_enable && !ready_act)
            cnt_next = '0;
         else
         begin
            state_next = next_phase(state_reg, tim_reg);
            cnt_next = phase_len(state_next, tim_reg) - ebrw_cnt_type'(1);
            if (state_next == ebrw_pkg::ST_IDLE)
               cnt_next = '0;
         end
      end
      // capture on the edge that lifts the read strobe, before any address moves
      if (state_reg == ebrw_pkg::ST_E && state_next != ebrw_pkg::ST_E && !wr_reg)
         rdata_next = i_cfg_mux_mode ? i_muxed_addr_data_lines : i_demuxed_data_lines;
      rsp_next = (state_reg != ebrw_pkg::ST_IDLE) && (state_next == ebrw_pkg::ST_IDLE);
   end

   // pad outputs decoded from the next state so they leave flops glitch-free
   always_comb
   begin
      cs_n_next = (state_next == ebrw_pkg::ST_IDLE);
      ale_next = (state_next == ebrw_pkg::ST_AB);
      rd_n_next = !(state_next == ebrw_pkg::ST_E && !wr_next);
      wr_n_next = !(state_next == ebrw_pkg::ST_E && wr_next);
      hbe_n_next = cs_n_next || !hb_next;
      mux_out_next = addr_next[15:0];
      mux_oe_n_next = 1'b1;
      dmx_oe_n_next = 1'b1;
      if (i_cfg_mux_mode)
      begin
         if (state_next == ebrw_pkg::ST_AB || state_next == ebrw_pkg::ST_C)
            mux_oe_n_next = 1'b0;
         else if (state_next != ebrw_pkg::ST_IDLE && wr_next)
         begin
            mux_out_next = wdata_next;
            mux_oe_n_next = 1'b0;
         end
      end
      else if (wr_next && (state_next == ebrw_pkg::ST_D || state_next == ebrw_pkg::ST_E ||
                           state_next == ebrw_pkg::ST_F))
         dmx_oe_n_next = 1'b0;
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_reg <= ebrw_pkg::ST_IDLE;
         cnt_reg <= '0;
         tim_reg <= '0;
         wr_reg <= 1'b0;
         hb_reg <= 1'b0;
         addr_reg <= `EBRW_ADDR_RST;
         wdata_reg <= `EBRW_DATA_RST;
         rdata_reg <= `EBRW_DATA_RST;
         rsp_reg <= 1'b0;
         cs_n_reg <= 1'b1;
         ale_reg <= 1'b0;
         rd_n_reg <= 1'b1;
         wr_n_reg <= 1'b1;
         hbe_n_reg <= 1'b1;
         mux_out_reg <= `EBRW_DATA_RST;
         mux_oe_n_reg <= 1'b1;
         dmx_oe_n_reg <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         tim_reg <= tim_next;
         wr_reg <= wr_next;
         hb_reg <= hb_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         rdata_reg <= rdata_next;
         rsp_reg <= rsp_next;
         cs_n_reg <= cs_n_next;
         ale_reg <= ale_next;
         rd_n_reg <= rd_n_next;
         wr_n_reg <= wr_n_next;
         hbe_n_reg <= hbe_n_next;
         mux_out_reg <= mux_out_next;
         mux_oe_n_reg <= mux_oe_n_next;
         dmx_oe_n_reg <= dmx_oe_n_next;
      end
   end

   assign o_rsp_valid = rsp_reg;
   assign o_rsp_rdata = rdata_reg;
   assign o_cs_n = cs_n_reg;
   assign o_ale = ale_reg;
   assign o_rd_n = rd_n_reg;
   assign o_wr_n = wr_n_reg;
   assign o_high_byte_enable_n = hbe_n_reg;
   assign o_demuxed_address_lines = addr_reg;
   assign o_muxed_addr_data_lines = mux_out_reg;
   assign o_muxed_addr_data_lines_oe_n = mux_oe_n_reg;
   assign o_demuxed_data_lines = wdata_reg;
   assign o_demuxed_data_lines_oe_n = dmx_oe_n_reg;

   sync_ready_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      sample_pt && i_cfg_ready_enable && !i_cfg_ready_async &&
      (i_ready == i_cfg_ready_active_high) |=> state_reg != ebrw_pkg::ST_E)
      else $error("sync wait active did not end access");
   async_stage_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      sample_pt && i_cfg_ready_enable && i_cfg_ready_async &&
      ($past(i_ready, 2) != i_cfg_ready_active_high) |=> state_reg == ebrw_pkg::ST_E)
      else $error("async wait used without synchroniser delay");
   wait_insert_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      sample_pt && i_cfg_ready_enable && !ready_act |=> sample_pt)
      else $error("no waitstate inserted on inactive wait");
   cycle_end_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      sample_pt && (ready_act || !i_cfg_ready_enable) |=> o_rd_n && o_wr_n)
      else $error("cycle not ended on active wait");
   mand_wait_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      state_reg == ebrw_pkg::ST_E && cnt_reg != '0 |=> state_reg == ebrw_pkg::ST_E)
      else $error("access phase left before mandatory waitstates");
   read_capture_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $rose(o_rd_n) && !i_cfg_mux_mode |-> o_rsp_rdata == $past(i_demuxed_data_lines))
      else $error("read data not captured at strobe rise");
   mux_addr_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_cfg_mux_mode && $stable(i_cfg_mux_mode) && o_ale |->
      !o_muxed_addr_data_lines_oe_n && o_muxed_addr_data_lines == o_demuxed_address_lines[15:0])
      else $error("address missing on shared lines");
   access_len_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $rose(state_reg == ebrw_pkg::ST_E) |->
      cnt_reg == ebrw_cnt_type'(tim_reg[`EBRW_E_LSB +: `EBRW_E_W]))
      else $error("access phase length wrong");
   phase_order_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      state_reg == ebrw_pkg::ST_F |=> state_reg inside {ebrw_pkg::ST_F, ebrw_pkg::ST_IDLE})
      else $error("hold phase not followed by idle");
   sync_chain_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      ##2 ready_s2_reg == $past(i_ready, 2))
      else $error("wait synchroniser is not two stages");
endmodule

// ==== core/ebrw_pkg.sv ====
// types of the external bus wait control
package ebrw_pkg;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_AB = 6'h02,
      ST_C = 6'h04,
      ST_D = 6'h08,
      ST_E = 6'h10,
      ST_F = 6'h20
   } ebrw_state_type;
endpackage

// ==== tb/ebrw_mem_model.sv ====
// memory and wait handshake model on the far side of the external bus
`timescale 1ns/10ps
module ebrw_mem_model (
   input wire logic i_clk,
   input wire logic [7:0] i_hold,
   input wire logic i_active_high,
   input wire logic i_mux_mode,
   input wire logic i_cs_n,
   input wire logic i_ale,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic [23:0] i_addr,
   input wire logic [15:0] i_mux_wire,
   input wire logic [15:0] i_dmx_wire,
   output logic o_ready,
   output logic [15:0] o_mux_drv,
   output logic [15:0] o_dmx_drv
);
   logic [15:0] mem [256];
   logic [7:0] cnt_reg = 8'h00;
   logic [7:0] mux_idx_reg = 8'h00;
   logic [15:0] junk_reg = 16'h0000;
   logic [7:0] idx;
   logic rdy_on;
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 16'hA5A5 ^ 16'(i);
   end
   assign idx = i_mux_mode ? mux_idx_reg : i_addr[7:0];
   always @(posedge i_clk)
   begin
      cnt_reg <= i_cs_n ? 8'h00 : ((cnt_reg == 8'hFF) ? cnt_reg : cnt_reg + 8'h01);
      junk_reg <= junk_reg + 16'h3B59;
      if (i_ale)
         mux_idx_reg <= i_mux_wire[7:0];
      if (!i_cs_n && !i_wr_n)
         mem[idx] <= i_mux_mode ? i_mux_wire : i_dmx_wire;
   end
   // wait stays active until the select ends, so it lasts at least as long as the strobe
   assign rdy_on = !i_cs_n && (cnt_reg >= i_hold);
   assign o_ready = i_active_high ? rdy_on : !rdy_on;
   // data only while read strobe low, else a pattern moving every cycle
   assign o_mux_drv = (!i_rd_n && !i_cs_n) ? mem[idx] : junk_reg;
   assign o_dmx_drv = o_mux_drv;
endmodule

// ==== tb/tb.sv ====
// self-checking testbench of the external bus wait control
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic mux = 1'b0, ren = 1'b0, asy = 1'b0, pol = 1'b1, valid = 1'b0, wr = 1'b0, hb = 1'b0;
   logic [51:0] tim = 52'h0;
   logic [1:0] sel = 2'h0;
   logic [23:0] addr = 24'h000000, dmx_addr;
   logic [15:0] wd = 16'h0000, rdata, mux_out, dmx_out, mux_w, dmx_w, mdl_mux, mdl_dmx;
   logic [7:0] hold = 8'h01;
   logic req_ready, rsp_valid, rdy, cs_n, ale, rd_n, wr_n, hbe_n, mux_oe_n, dmx_oe_n, ref_clk;
   logic [15:0] shadow [256];
   int err_total = 0, n_tests = 0, cyc = 0;
   assign mux_w = mux_oe_n ? mdl_mux : mux_out;
   assign dmx_w = dmx_oe_n ? mdl_dmx : dmx_out;
   ebrw_ctrl #(.NUM_SEL(4), .SEL_W(2)) dut (.i_clk(clk), .i_resetn(resetn),
      .i_cfg_mux_mode(mux), .i_cfg_ready_enable(ren), .i_cfg_ready_async(asy),
      .i_cfg_ready_active_high(pol), .i_per_select_timing_config(tim), .i_req_valid(valid),
      .o_req_ready(req_ready), .i_req_write(wr), .i_req_sel(sel), .i_req_addr(addr),
      .i_req_wdata(wd), .i_req_high_byte(hb), .o_rsp_valid(rsp_valid), .o_rsp_rdata(rdata),
      .i_ready(rdy), .o_bus_reference_clock_out(ref_clk), .o_cs_n(cs_n), .o_ale(ale),
      .o_rd_n(rd_n), .o_wr_n(wr_n), .o_high_byte_enable_n(hbe_n),
      .o_demuxed_address_lines(dmx_addr),
      .i_muxed_addr_data_lines(mux_w), .o_muxed_addr_data_lines(mux_out),
      .o_muxed_addr_data_lines_oe_n(mux_oe_n), .i_demuxed_data_lines(dmx_w),
      .o_demuxed_data_lines(dmx_out), .o_demuxed_data_lines_oe_n(dmx_oe_n));
   // partner runs off the forwarded reference clock, as a real one would
   ebrw_mem_model mdl (.i_clk(ref_clk), .i_hold(hold), .i_active_high(pol), .i_mux_mode(mux),
      .i_cs_n(cs_n), .i_ale(ale), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(dmx_addr),
      .i_mux_wire(mux_w), .i_dmx_wire(dmx_w), .o_ready(rdy), .o_mux_drv(mdl_mux),
      .o_dmx_drv(mdl_dmx));
   initial
   begin
      forever #25 clk = ~clk;
   end
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // cycles from accept to response pulse; async pin seen two edges late
   function automatic int exp_len(logic [12:0] t, logic en, logic am, int hd);
      int p, e, w;
      p = ((t[2:0] == 3'h0) ? 1 : int'(t[2:0])) + int'(t[4:3]) + int'(t[5]);
      e = int'(t[10:6]) + 1;
      w = en ? hd + (am ? 3 : 1) - p - e : 0;
      if (w < 0)
         w = 0;
      return p + e + w + int'(t[12:11]);
   endfunction
   task automatic xfer;
      int n, ex;
      check("ready idle", req_ready, 1);
      valid = 1'b1;
      @(posedge clk);
      #2;
      valid = 1'b0;
      check("busy", req_ready, 0);
      check("start", {cs_n, ale, hbe_n}, {2'b01, !hb});
      if (mux)
         check("mux addr", {mux_oe_n, mux_out}, {1'b0, addr[15:0]});
      else
         check("addr", dmx_addr, addr);
      n = 0;
      while (rsp_valid !== 1'b1 && n < 300)
      begin
         @(posedge clk);
         #2;
         n++;
      end
      ex = exp_len(tim[sel*13 +: 13], ren, asy, int'(hold));
      check("length", n, ex);
      if (wr)
         shadow[addr[7:0]] = wd;
      else
         check("rdata", rdata, shadow[addr[7:0]]);
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         err_total++;
         $display("timeout");
         wrap_up();
      end
   end
   initial
   begin
      for (int i = 0; i < 256; i++)
         shadow[i] = 16'hA5A5 ^ 16'(i);
      void'($urandom(32'h7727));
      repeat (20) @(posedge clk);
      #2;
      resetn = 1'b1;
      check("reset", {cs_n, rd_n, wr_n, ale, rsp_valid}, 5'b11100);
      check("ref clock", ref_clk, 1'b1);
      for (int g = 0; g < 16; g++)
      begin
         {pol, asy, ren, mux} = 4'(g);
         // select 0 shortest cycle, select 1 longest, others random
         tim = {13'($urandom), 13'($urandom), 13'h1FFF, 13'h0000};
         for (int k = 0; k < 14; k++)
         begin
            sel = 2'($urandom);
            wr = (k < 2) ? 1'b1 : 1'($urandom);
            addr = {20'($urandom), 4'($urandom)};
            wd = 16'($urandom);
            hb = 1'($urandom);
            hold = (k == 3) ? 8'h01 : 8'h01 + 8'($urandom % 40);
            xfer();
         end
      end
      wrap_up();
   end
endmodule
